// ---- brsc_bank.sv ----
/*
  One bank: open-row tracking, precharge timing, auto precharge and
  store-time blocking.
  Assumes commands arrive already decoded and at most one per cycle.
*/
`timescale 1ns/1ps
`include "brsc_cfg.svh"
module brsc_bank
  import brsc_pkg::*;
#(
  parameter int ST_CYC = `BRSC_ST_CYC
) (
  input wire logic mclk,
  input wire logic sys_rst,
  brsc_cmd_if.dst cmd,
  output logic row_open,
  output logic [15:0] open_row,
  output logic ready,
  output logic storing
);
  // ----------------------------------------------------------------------
  // State and timers
  // ----------------------------------------------------------------------
  brsc_bank_state_t st_q, st_d;
  logic [15:0] tmr_q, tmr_d; // Precharge or store countdown.
  logic [15:0] row_q; // Latched open row.
  logic [3:0] ap_q, ap_d; // Burst countdown before auto precharge.
  logic ap_arm_q, ap_arm_d; // Auto precharge pending.
  wire logic tmr_done = (tmr_q == 16'h0001) || (tmr_q == 16'h0000);

  assign row_open = (st_q == BRSC_OPEN);
  assign open_row = row_q;
  assign ready = (st_q == BRSC_IDLE);
  assign storing = (st_q == BRSC_STORE);

  // Next state; a store takes priority, then an explicit precharge.
  always_comb begin
    st_d = st_q;
    tmr_d = (tmr_q != 16'h0000) ? tmr_q - 16'h0001 : 16'h0000;
    ap_d = (ap_q != 4'h0) ? ap_q - 4'h1 : 4'h0;
    ap_arm_d = ap_arm_q;
    case (st_q)
      BRSC_IDLE: begin
        if (cmd.act) begin
          st_d = BRSC_OPEN;
        end
      end
      BRSC_OPEN: begin
        if (cmd.rdwr_ap) begin
          ap_arm_d = 1'b1;
          ap_d = 4'(`BRSC_BURST_CYC);
        end
        if (cmd.pre || (ap_arm_q && ap_q == 4'h1)) begin
          st_d = BRSC_PRECH;
          tmr_d = 16'(`BRSC_RP_CYC);
          ap_arm_d = 1'b0;
        end
      end
      BRSC_PRECH: begin
        if (tmr_done) begin
          st_d = BRSC_IDLE;
        end
      end
      BRSC_STORE: begin
        if (tmr_done) begin
          st_d = BRSC_IDLE;
        end
      end
      default: begin
        st_d = BRSC_IDLE;
      end
    endcase
    if (cmd.pre && (st_q == BRSC_IDLE || st_q == BRSC_PRECH)) begin
      st_d = BRSC_PRECH;
      tmr_d = 16'(`BRSC_RP_CYC);
    end
    if (cmd.store) begin
      st_d = BRSC_STORE;
      tmr_d = 16'(ST_CYC);
      ap_arm_d = 1'b0;
    end
  end

  // Registers; the row latch only loads on an accepted activate.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q <= BRSC_IDLE;
      tmr_q <= 16'h0000;
      ap_q <= 4'h0;
      ap_arm_q <= 1'b0;
      row_q <= 16'h0000;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      ap_q <= ap_d;
      ap_arm_q <= ap_arm_d;
      if (cmd.act && st_q == BRSC_IDLE) begin
        row_q <= cmd.row;
      end
    end
  end
endmodule

// ---- brsc_cfg.svh ----
/*
  Constants for the bank row and store control block: command codes,
  field positions, reset values and timing counts.
  Assumes a 25 MHz command clock (40 ns period).
*/
`ifndef BRSC_CFG_SVH
`define BRSC_CFG_SVH

// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define BRSC_CLK_PS 40000
`define BRSC_ST_TIME_PS 380000
`define BRSC_ST_CYC ((`BRSC_ST_TIME_PS + `BRSC_CLK_PS - 1) / `BRSC_CLK_PS)
`define BRSC_RP_TIME_PS 15000
`define BRSC_RP_CYC ((`BRSC_RP_TIME_PS + `BRSC_CLK_PS - 1) / `BRSC_CLK_PS)
`define BRSC_BURST_CYC 4

// ----------------------------------------------------------------------
// Command codes on cmd_code
// ----------------------------------------------------------------------
`define BRSC_CMD_NOP 3'h0
`define BRSC_CMD_ACT 3'h1
`define BRSC_CMD_PRE 3'h2
`define BRSC_CMD_RD 3'h3
`define BRSC_CMD_WR 3'h4
`define BRSC_CMD_REF 3'h5
`define BRSC_CMD_MRS3 3'h6

// ----------------------------------------------------------------------
// Mode register fields and the auto precharge bit
// ----------------------------------------------------------------------
`define BRSC_MR_STORE_EN_BIT 8
`define BRSC_MR_STAGGER_HI 7
`define BRSC_MR_STAGGER_LO 6
`define BRSC_STAGGER_OK 2'h2
`define BRSC_MR_RESET 9'h080
`define BRSC_AP_BIT 10

`endif

// ---- brsc_pkg.sv ----
/*
  Types for the bank row and store control block.
  Assumes brsc_cfg.svh supplies the numeric constants.
*/
package brsc_pkg;
  // Per-bank state, one-hot.
  typedef enum logic [3:0] {
    BRSC_IDLE = 4'h1,
    BRSC_OPEN = 4'h2,
    BRSC_PRECH = 4'h4,
    BRSC_STORE = 4'h8
  } brsc_bank_state_t;
endpackage

// ---- brsc_cmd_if.sv ----
/*
  Interface carrying one decoded bank command from the top to a bank.
  Assumes both ends share mclk.
*/
`timescale 1ns/1ps
interface brsc_cmd_if;
  logic act; // Activate this bank.
  logic pre; // Precharge this bank.
  logic rdwr_ap; // Read or write with auto precharge.
  logic rdwr; // Any read or write to this bank.
  logic store; // Start a store in this bank.
  logic [15:0] row; // Row address for an activate.
  modport src (output act, pre, rdwr_ap, rdwr, store, row);
  modport dst (input act, pre, rdwr_ap, rdwr, store, row);
endinterface

// ---- brsc_top.sv ----
/*
  Bank row and store control: decodes commands per bank, holds the
  store configuration mode register and drives per-bank status.
  Assumes the command bus is synchronous to mclk, one command a cycle,
  and that the controller keeps its own spacing limits.
*/
// What this block does
// - Activate takes group, bank and row.
// - Row stays open until precharge or store.
// - Precharge closes one or all banks.
// - Other-bank access allowed during auto precharge.
// - Precharge to idle bank restarts timer.
// - Address bit ten enables auto precharge.
// - One page buffer per bank.
// - Refresh stores all when enabled.
// - Refresh ignored when store disabled.
// - Store blocks activation for store time.
// - Bit ten selects single or all store.
// - Only stagger code 10 is supported.
// - Store time from banks per update, never under 380 ns.
`timescale 1ns/1ps
`include "brsc_cfg.svh"
module brsc_top
  import brsc_pkg::*;
#(
  parameter int NUM_BANKS = 16,
  parameter int BANKS_PER_UPDATE = 8,
  parameter int ROW_CYCLE_PS = 47500
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [2:0] cmd_code,
  input wire logic cmd_store,
  input wire logic [1:0] bg,
  input wire logic [1:0] ba,
  input wire logic [15:0] addr,
  output logic [NUM_BANKS-1:0] bank_open,
  output logic [NUM_BANKS-1:0] bank_ready,
  output logic [NUM_BANKS-1:0] bank_storing,
  output logic [8:0] store_config_mode_register,
  output logic stagger_unsupported,
  output logic cmd_error
);
  // ----------------------------------------------------------------------
  // Store time derivation
  // ----------------------------------------------------------------------
  // Store time from banks.
  // Update passes times the row cycle, rounded up to whole clocks.
  localparam int ST_PS = (NUM_BANKS / BANKS_PER_UPDATE) * ROW_CYCLE_PS;
  localparam int ST_CYC_CALC = (ST_PS + `BRSC_CLK_PS - 1) / `BRSC_CLK_PS;
  // The supported stagger code makes 380 ns a floor for the store time.
  localparam int ST_CYC = (ST_CYC_CALC > `BRSC_ST_CYC) ? ST_CYC_CALC
                                                       : `BRSC_ST_CYC;

  // ----------------------------------------------------------------------
  // Mode register
  // ----------------------------------------------------------------------
  logic [8:0] mr_q; // Store configuration mode register.
  wire logic refresh_store_enable_bit = mr_q[`BRSC_MR_STORE_EN_BIT];
  wire logic [1:0] bank_stagger_select_field =
    mr_q[`BRSC_MR_STAGGER_HI:`BRSC_MR_STAGGER_LO];

  // Mode register write; only the low nine address bits are held.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mr_q <= `BRSC_MR_RESET;
    end else if (cmd_code == `BRSC_CMD_MRS3) begin
      mr_q <= addr[8:0];
    end
  end

  assign store_config_mode_register = mr_q;
  assign stagger_unsupported = (bank_stagger_select_field != `BRSC_STAGGER_OK);

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------
  // Bank from group and bank.
  wire logic [3:0] sel_bank = {bg, ba};
  wire logic ap = addr[`BRSC_AP_BIT];
  wire logic is_act = (cmd_code == `BRSC_CMD_ACT);
  wire logic is_pre = (cmd_code == `BRSC_CMD_PRE);
  wire logic is_rdwr = (cmd_code == `BRSC_CMD_RD) ||
                       (cmd_code == `BRSC_CMD_WR);
  wire logic ref_store = (cmd_code == `BRSC_CMD_REF) &&
                         refresh_store_enable_bit;
  wire logic st_all = ref_store || (cmd_store && ap);
  wire logic st_one = cmd_store && !ap;

  // ----------------------------------------------------------------------
  // Banks
  // ----------------------------------------------------------------------
  logic [NUM_BANKS-1:0] bad_act; // Activate to a bank not idle.
  logic [NUM_BANKS-1:0] bad_rdwr; // Access to a bank with no open row.

  genvar gi;
  generate
    for (gi = 0; gi < NUM_BANKS; gi = gi + 1) begin : g_bank
      brsc_cmd_if bif ();
      wire logic hit = (sel_bank == 4'(gi));
      assign bif.act = is_act && hit;
      assign bif.pre = is_pre && (hit || ap);
      assign bif.rdwr_ap = is_rdwr && hit && ap;
      assign bif.rdwr = is_rdwr && hit;
      assign bif.store = st_all || (st_one && hit);
      assign bif.row = addr;
      assign bad_act[gi] = bif.act && !bank_ready[gi];
      assign bad_rdwr[gi] = bif.rdwr && !bank_open[gi];
      brsc_bank #(
        .ST_CYC(ST_CYC)
      ) u_bank (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .cmd(bif.dst),
        .row_open(bank_open[gi]),
        .open_row(),
        .ready(bank_ready[gi]),
        .storing(bank_storing[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Error flag
  // ----------------------------------------------------------------------
  // A one-cycle pulse, registered, when the controller breaks ordering.
  // Spacing limits between activates are not checked here; they are the
  // controller's own duty and cost a timer per group to police.
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cmd_error <= 1'b0;
    end else begin
      cmd_error <= (|bad_act) || (|bad_rdwr);
    end
  end
endmodule

// ---- brsc_top_asserts.sv ----
/* Concurrent checks on the ports of the bank row and store control top.
   Assumes one clock domain, mclk, with synchronous reset sys_rst. */
`timescale 1ns/1ps
`include "brsc_cfg.svh"
module brsc_top_asserts #(parameter int NUM_BANKS = 16) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [2:0] cmd_code,
  input wire logic cmd_store,
  input wire logic [1:0] bg,
  input wire logic [1:0] ba,
  input wire logic [15:0] addr,
  input wire logic [NUM_BANKS-1:0] bank_open,
  input wire logic [NUM_BANKS-1:0] bank_ready,
  input wire logic [NUM_BANKS-1:0] bank_storing,
  input wire logic [8:0] store_config_mode_register,
  input wire logic stagger_unsupported,
  input wire logic cmd_error
);
  // A store strobe overrides the code, so every decode excludes it.
  wire [3:0] bk = {bg, ba};
  wire op = !cmd_store;
  wire act = op && cmd_code == `BRSC_CMD_ACT;
  wire pre = op && cmd_code == `BRSC_CMD_PRE;
  wire rw = op && (cmd_code == `BRSC_CMD_RD || cmd_code == `BRSC_CMD_WR);
  wire ref_en = op && cmd_code == `BRSC_CMD_REF;
  wire en = store_config_mode_register[8];
  default clocking @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  a_act_opens: assert property (
    act && bank_ready[bk] |=> bank_open[$past(bk)]) else $error("no open");
  a_act_refused: assert property (
    act && !bank_ready[bk] |=> cmd_error) else $error("no refusal");
  a_rdwr_refused: assert property (
    rw && !bank_open[bk] |=> cmd_error) else $error("no access refusal");
  a_pre_one: assert property (
    pre && !addr[10] && bank_open[bk] ##1 op && cmd_code == `BRSC_CMD_NOP
    |-> !bank_open[$past(bk)] ##1 bank_ready[$past(bk, 2)])
    else $error("precharge timing");
  a_pre_all: assert property (
    pre && addr[10] |=> bank_open == '0) else $error("precharge all");
  a_auto_pre: assert property (
    rw && addr[10] && bank_open[bk] |-> ##4 bank_open[$past(bk, 4)]
    ##1 !bank_open[$past(bk, 5)]) else $error("auto precharge");
  a_ref_store: assert property (
    ref_en && en |=> &bank_storing) else $error("no store all");
  a_ref_ignored: assert property (
    ref_en && !en && bank_storing == '0 |=> bank_storing == '0)
    else $error("store ran");
  a_store_time: assert property (
    $rose(bank_storing[0]) |-> bank_storing[0] [*8] ##1 bank_storing[0]
    ##1 bank_storing[0] ##1 bank_ready[0]) else $error("store time");
  a_store_one: assert property (
    cmd_store && !addr[10] && bank_storing == '0 |=>
    bank_storing == (NUM_BANKS'(1) << $past(bk))) else $error("one store");
  cover property (ref_en && en);
  cover property (rw && addr[10] && bank_open[bk]);
  cover property (cmd_error);
endmodule
bind brsc_top brsc_top_asserts #(.NUM_BANKS(NUM_BANKS)) u_chk (
  .mclk(mclk), .sys_rst(sys_rst), .cmd_code(cmd_code),
  .cmd_store(cmd_store), .bg(bg), .ba(ba), .addr(addr),
  .bank_open(bank_open), .bank_ready(bank_ready),
  .bank_storing(bank_storing),
  .store_config_mode_register(store_config_mode_register),
  .stagger_unsupported(stagger_unsupported), .cmd_error(cmd_error));

// ---- brsc_host_model.sv ----
/* Host memory controller model driving the command bus.
   Assumes the bench calls issue for every command, one at a time. */
`timescale 1ns/1ps
`include "brsc_cfg.svh"
module brsc_host_model (
  input wire logic mclk,
  output logic [2:0] cmd_code,
  output logic cmd_store,
  output logic [1:0] bg,
  output logic [1:0] ba,
  output logic [15:0] addr
);
  initial {cmd_code, cmd_store, bg, ba, addr} = '0;
  // Callers may access a closed bank; the bench does so to test refusal.
  // Commands go out singly, a free cycle between.
  task automatic issue(input logic [2:0] c, input logic s,
      input logic [3:0] b, input logic [15:0] a);
    @(negedge mclk);
    {cmd_code, cmd_store, bg, ba, addr} = {c, s, b, a};
    @(negedge mclk);
    // Released bank and address lines show the inverse, so stale values never pass.
    {cmd_code, cmd_store, bg, ba, addr} = {3'h0, 1'b0, ~b, ~a};
  endtask
endmodule

// ---- test_bank_row_and_store_control.sv ----
/* Self-checking bench for the bank row and store control block.
   Assumes the host model drives commands on falling edges. */
`timescale 1ns/1ps
`include "brsc_cfg.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
  mismatches++; $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module test_bank_row_and_store_control;
  // A 380 ns store at a 40 ns clock, rounded up to whole cycles.
  localparam int ST_EXP = (380 + 39) / 40;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  wire [2:0] cmd_code;
  wire cmd_store, unsup, cmd_error;
  wire [1:0] bg, ba;
  wire [15:0] addr, bank_open, bank_ready, bank_storing;
  wire [8:0] mode;
  int mismatches = 0;
  int total_checks = 0;
  always #20 mclk = ~mclk;
  brsc_host_model u_host (.mclk(mclk), .cmd_code(cmd_code),
    .cmd_store(cmd_store), .bg(bg), .ba(ba), .addr(addr));
  brsc_top u_dut (.mclk(mclk), .sys_rst(sys_rst), .cmd_code(cmd_code),
    .cmd_store(cmd_store), .bg(bg), .ba(ba), .addr(addr),
    .bank_open(bank_open), .bank_ready(bank_ready),
    .bank_storing(bank_storing), .store_config_mode_register(mode),
    .stagger_unsupported(unsup), .cmd_error(cmd_error));
  task automatic go(input logic [2:0] c, input logic s,
      input logic [3:0] b, input logic [15:0] a);
    u_host.issue(c, s, b, a);
  endtask
  // Waits, bounded, for every store to end, checks the cycles waited from the call, and checks that all banks are ready.
  task automatic wait_store(input int exp);
    int n;
    n = 0;
    while (|bank_storing === 1'b1 && n < 40) begin
      n++;
      @(negedge mclk);
    end
    `CHK(n, exp)
    `CHK(bank_ready, 16'hFFFF)
    if (n == 40) stop_test();
  endtask
  task automatic t_rows();
    go(`BRSC_CMD_ACT, 1'b0, 4'hD, 16'hBEEF);
    `CHK(bank_open, 16'h2000)
    go(`BRSC_CMD_ACT, 1'b0, 4'hD, 16'h0001);
    `CHK({cmd_error, bank_open[13]}, 2'b11)
    go(`BRSC_CMD_PRE, 1'b0, 4'hD, 16'h0000);
    `CHK({bank_open[13], bank_ready[13]}, 2'b00)
    go(`BRSC_CMD_PRE, 1'b0, 4'hD, 16'h0000);
    `CHK({cmd_error, bank_ready[13]}, 2'b00)
    go(`BRSC_CMD_ACT, 1'b0, 4'h2, 16'h0010);
    go(`BRSC_CMD_ACT, 1'b0, 4'hC, 16'h0020);
    go(`BRSC_CMD_RD, 1'b0, 4'h2, 16'h0400);
    go(`BRSC_CMD_WR, 1'b0, 4'hC, 16'h0000);
    `CHK({cmd_error, bank_open[2]}, 2'b01)
    @(negedge mclk);
    `CHK(bank_open[2], 1'b1)
    @(negedge mclk);
    `CHK({bank_open[2], bank_ready[2]}, 2'b00)
    go(`BRSC_CMD_PRE, 1'b0, 4'h0, 16'h0400);
    `CHK(bank_open, 16'h0000)
    go(`BRSC_CMD_RD, 1'b0, 4'h5, 16'h0000);
    `CHK(cmd_error, 1'b1)
  endtask
  task automatic t_store();
    go(`BRSC_CMD_REF, 1'b0, 4'h0, 16'h0000);
    `CHK(bank_storing, 16'h0000)
    go(`BRSC_CMD_MRS3, 1'b0, 4'h0, 16'h0180);
    `CHK(mode, 9'h180)
    go(`BRSC_CMD_REF, 1'b0, 4'h0, 16'h0000);
    `CHK({bank_storing, bank_ready}, 32'hFFFF_0000)
    wait_store(ST_EXP);
    go(`BRSC_CMD_NOP, 1'b1, 4'h9, 16'h0000);
    `CHK(bank_storing, 16'h0200)
    go(`BRSC_CMD_ACT, 1'b0, 4'h9, 16'h0000);
    `CHK({cmd_error, bank_open[9]}, 2'b10)
    wait_store(ST_EXP - 2);
    go(`BRSC_CMD_NOP, 1'b1, 4'h0, 16'h0400);
    `CHK(bank_storing, 16'hFFFF)
    wait_store(ST_EXP);
    for (int i = 0; i < 4; i++) begin
      go(`BRSC_CMD_MRS3, 1'b0, 4'h0, {8'h01, i[1:0], 6'h00});
      `CHK(unsup, i != 2)
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge mclk);
    @(negedge mclk);
    sys_rst = 1'b0;
    `CHK({bank_ready, mode}, {16'hFFFF, 9'h080})
    t_rows();
    t_store();
    stop_test();
  end
endmodule
